// file: dv/mne_exec_unit_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mne_exec_unit_sva (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        arst_n_i,
  input wire logic        clk_en_i,
  // Instruction and operands
  input wire logic        instr_valid_i,
  input wire logic [23:0] instr_word_i,
  input wire logic [15:0] base_val_i,
  input wire logic [15:0] src_val_i,
  input wire logic [39:0] acc_a_i,
  input wire logic [39:0] acc_b_i,
  // Results
  input wire logic [1:0]  rf_we_o,
  input wire logic [3:0]  rf_idx0_o,
  input wire logic [15:0] rf_dat0_o,
  input wire logic [3:0]  rf_idx1_o,
  input wire logic [15:0] rf_dat1_o,
  input wire logic        mem_we_o,
  input wire logic        acc_we_o,
  input wire logic        acc_sel_o,
  input wire logic [39:0] acc_dat_o,
  input wire logic        sr_we_o,
  input wire logic        done_o
);
  // Instruction class decode
  wire v    = instr_valid_i & clk_en_i;
  wire mul  = v && instr_word_i[23:16] == 8'hb8;
  wire lit  = mul && !instr_word_i[15] && instr_word_i[6:5] == 2'h3;
  wire uu   = mul && !instr_word_i[15] && instr_word_i[6:5] != 2'h3;
  wire us   = mul && instr_word_i[15];
  wire nacc = v && instr_word_i[23:16] == 8'hcb && instr_word_i[14:12] == 3'h1;
  wire nf1  = v && {instr_word_i[23:15], instr_word_i[13]} == 10'h3b9;
  // Reference results
  logic signed [31:0] p_us;
  logic        [31:0] p_uu;
  logic        [39:0] n_acc;
  wire         [31:0] prod = {rf_dat1_o, rf_dat0_o};
  assign p_us  = $signed({1'b0, base_val_i}) * $signed(src_val_i);
  assign p_uu  = lit ? base_val_i * instr_word_i[4:0] : base_val_i * src_val_i;
  assign n_acc = 40'h0 - (instr_word_i[15] ? acc_b_i : acc_a_i);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  chk_mul_pair: assert property (mul |=> rf_we_o == 2'h3 && rf_idx0_o == $past(instr_word_i[10:7]) &&
    rf_idx1_o == ($past(instr_word_i[10:7]) | 4'h1)) else $error("multiply pair wrong");
  chk_mul_signed: assert property (us |=> signed'(prod) == $past(p_us)) else $error("mixed product wrong");
  chk_mul_unsigned: assert property (uu |=> prod == $past(p_uu)) else $error("unsigned product wrong");
  chk_mul_literal: assert property (lit |=> prod == $past(p_uu)) else $error("literal product wrong");
  chk_mul_flags: assert property (mul |=> !sr_we_o) else $error("multiply touched flags");
  chk_acc_negate: assert property (nacc |=> acc_we_o && acc_sel_o == $past(instr_word_i[15]) &&
    acc_dat_o == $past(n_acc)) else $error("accumulator negate wrong");
  chk_acc_flags: assert property (nacc |=> sr_we_o) else $error("accumulator flags not written");
  chk_file_dest: assert property (nf1 |=> mem_we_o && rf_we_o == 2'h0) else $error("file negate dest wrong");
  chk_done_cause: assert property (done_o |-> $past(v)) else $error("done without instruction");
  chk_one_cycle: assert property ((mul || nacc || nf1) |=> done_o) else $error("not done in one cycle");
endmodule
bind mne_exec_unit mne_exec_unit_sva i_mne_exec_unit_sva (.clock_i, .arst_n_i, .clk_en_i, .instr_valid_i,
  .instr_word_i, .base_val_i, .src_val_i, .acc_a_i, .acc_b_i, .rf_we_o, .rf_idx0_o, .rf_dat0_o, .rf_idx1_o,
  .rf_dat1_o, .mem_we_o, .acc_we_o, .acc_sel_o, .acc_dat_o, .sr_we_o, .done_o);
`default_nettype wire

// file: dv/mne_exec_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mne_exec_unit_tb_top;
  // Bench signals and links
  logic clock_i, arst_n_i, clk_en_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o, instr_valid_i;
  logic [4:0] avs_address_i;
  logic [3:0] avs_byteenable_i, base_idx_o, src_idx_o, rf_idx0_o, rf_idx1_o;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [23:0] instr_word_i;
  logic [2:0] src_mode_o;
  logic [12:0] file_addr_o, mem_addr_o;
  logic [15:0] base_val_i, src_val_i, file_val_i, sr_i, rf_dat0_o, rf_dat1_o, mem_dat_o, sr_dat_o, sr_mask_o;
  logic [39:0] acc_a_i, acc_b_i, acc_dat_o;
  logic [1:0] rf_we_o, rf_be0_o, mem_be_o;
  logic mem_we_o, acc_we_o, acc_sel_o, sr_we_o;
  int err_count, tests_run;
  // Clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  mne_exec_unit i_mne_exec_unit (.clock_i, .arst_n_i, .clk_en_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .instr_valid_i,
    .instr_word_i, .base_idx_o, .src_idx_o, .src_mode_o, .dst_mode_o(), .file_addr_o, .op_o(), .base_val_i,
    .src_val_i, .file_val_i, .acc_a_i, .acc_b_i, .sr_i, .rf_we_o, .rf_be0_o, .rf_idx0_o, .rf_dat0_o, .rf_idx1_o,
    .rf_dat1_o, .rf_mode0_o(), .mem_we_o, .mem_be_o, .mem_addr_o, .mem_dat_o, .acc_we_o, .acc_sel_o, .acc_dat_o,
    .sr_we_o, .sr_dat_o, .sr_mask_o, .done_o());
  mne_rf_model i_mne_rf_model (.clock_i, .base_idx_i(base_idx_o), .src_idx_i(src_idx_o), .src_mode_i(src_mode_o),
    .file_addr_i(file_addr_o), .base_val_o(base_val_i), .src_val_o(src_val_i), .file_val_o(file_val_i),
    .acc_a_o(acc_a_i), .acc_b_o(acc_b_i), .sr_o(sr_i), .rf_we_i(rf_we_o), .rf_be0_i(rf_be0_o),
    .rf_idx0_i(rf_idx0_o), .rf_dat0_i(rf_dat0_o), .rf_idx1_i(rf_idx1_o), .rf_dat1_i(rf_dat1_o),
    .mem_we_i(mem_we_o), .mem_be_i(mem_be_o), .mem_addr_i(mem_addr_o), .mem_dat_i(mem_dat_o),
    .acc_we_i(acc_we_o), .acc_sel_i(acc_sel_o), .acc_dat_i(acc_dat_o), .sr_we_i(sr_we_o), .sr_dat_i(sr_dat_o),
    .sr_mask_i(sr_mask_o));
  // Verdict and end of run
  task automatic test_done();
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compare one value
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Avalon-MM access held until waitrequest is low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) begin
      n++;
      if (n > 20) begin
        err_count++;
        test_done();
      end
      @(posedge clock_i);
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  // One or two instructions on consecutive edges
  task automatic ex(input logic [23:0] a, input logic [23:0] b);
    @(posedge clock_i);
    instr_valid_i <= 1'b1;
    instr_word_i <= a;
    if (b !== 24'h0) begin
      @(posedge clock_i);
      instr_word_i <= b;
    end
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask
  // Main sequence
  initial begin
    {arst_n_i, avs_read_i, avs_write_i, instr_valid_i, avs_address_i, avs_writedata_i, instr_word_i} = '0;
    clk_en_i = 1'b1;
    avs_byteenable_i = 4'hf;
    i_mne_rf_model.sr = 16'h0;
    i_mne_rf_model.w = '{0: 16'hffff, 4: 16'hffff, 6: 16'hffff, 5: 16'h0c00, default: 16'h0};
    i_mne_rf_model.mem[12'hc00] = 16'h7fff;
    repeat (16) @(posedge clock_i);
    arst_n_i <= 1'b1;
    bus(1'b0, 5'h00, 32'h0);
    cmp(rd, 40'h1);
    bus(1'b0, 5'h1c, 32'h0);
    cmp(rd, 40'h0);
    // Unsigned register and literal 31, then mixed indirect and direct; even pairs only
    ex(24'hb82100, 24'hb8067f);
    cmp({i_mne_rf_model.w[3], i_mne_rf_model.w[2]}, 40'hfffe0001);
    cmp({i_mne_rf_model.w[13], i_mne_rf_model.w[12]}, 40'h001effe1);
    i_mne_rf_model.w[0] = 16'hc000;
    i_mne_rf_model.w[1] = 16'hf000;
    ex(24'hb8b515, 24'hb88101);
    cmp({i_mne_rf_model.w[11], i_mne_rf_model.w[10]}, 40'h7ffe8001);
    cmp({i_mne_rf_model.w[3], i_mne_rf_model.w[2]}, 40'hf4000000);
    cmp(i_mne_rf_model.sr, 40'h0);
    // File negate: byte to default register, then word back to memory
    i_mne_rf_model.w[0] = 16'h9080;
    i_mne_rf_model.mem[13'h880] = 16'h2355;
    i_mne_rf_model.mem[13'h1200] = 16'h8000;
    ex(24'hee4880, 24'h0);
    cmp(i_mne_rf_model.w[0], 40'h90ab);
    cmp(i_mne_rf_model.sr, 40'h0008);
    ex(24'hee3200, 24'h0);
    cmp(i_mne_rf_model.mem[13'h1200], 40'h8000);
    cmp(i_mne_rf_model.w[0], 40'h90ab);
    cmp(i_mne_rf_model.sr, 40'h010c);
    // Register negate and both accumulators back to back
    i_mne_rf_model.w[3] = 16'h0001;
    i_mne_rf_model.acc_a = 40'h003290_59c8;
    i_mne_rf_model.acc_b = 40'hfff230_10dc;
    ex(24'hea0283, 24'h0);
    cmp(i_mne_rf_model.w[5], 40'hffff);
    ex(24'hcb1000, 24'hcb9000);
    cmp(i_mne_rf_model.acc_a, 40'hffcd6fa638);
    cmp(i_mne_rf_model.acc_b, 40'h000dcfef24);
    // Frozen clock enable, then disabled unit: no write-back
    i_mne_rf_model.w[3] = 16'h0002;
    clk_en_i <= 1'b0;
    ex(24'hea0283, 24'h0);
    cmp(i_mne_rf_model.w[5], 40'hffff);
    clk_en_i <= 1'b1;
    bus(1'b1, 5'h00, 32'h0);
    ex(24'hea0283, 24'h0);
    cmp(i_mne_rf_model.w[5], 40'hffff);
    bus(1'b1, 5'h00, 32'h1);
    // Event status, mask and interrupt
    bus(1'b0, 5'h04, 32'h0);
    cmp(rd, 40'h3);
    bus(1'b1, 5'h08, 32'h2);
    @(negedge clock_i);
    cmp(irq_o, 40'h1);
    bus(1'b1, 5'h04, 32'h2);
    @(negedge clock_i);
    cmp(irq_o, 40'h0);
    bus(1'b0, 5'h04, 32'h0);
    cmp(rd, 40'h1);
    // Odd destination pair and unknown opcode raise their events
    ex(24'hb80180, 24'hff0000);
    bus(1'b0, 5'h04, 32'h0);
    cmp(rd, 40'hd);
    bus(1'b0, 5'h0c, 32'h0);
    cmp(rd, 40'ha);
    bus(1'b0, 5'h10, 32'h0);
    cmp(rd, 40'h51c0d239);
    test_done();
  end
endmodule
`default_nettype wire

// file: dv/mne_rf_model.sv
`timescale 1ns/1ps
`default_nettype none
module mne_rf_model (
  // Clock and operand requests
  input  wire logic        clock_i,
  input  wire logic [3:0]  base_idx_i,
  input  wire logic [3:0]  src_idx_i,
  input  wire logic [2:0]  src_mode_i,
  input  wire logic [12:0] file_addr_i,
  // Operand values
  output logic      [15:0] base_val_o,
  output logic      [15:0] src_val_o,
  output logic      [15:0] file_val_o,
  output logic      [39:0] acc_a_o,
  output logic      [39:0] acc_b_o,
  output logic      [15:0] sr_o,
  // Write ports
  input  wire logic [1:0]  rf_we_i,
  input  wire logic [1:0]  rf_be0_i,
  input  wire logic [3:0]  rf_idx0_i,
  input  wire logic [15:0] rf_dat0_i,
  input  wire logic [3:0]  rf_idx1_i,
  input  wire logic [15:0] rf_dat1_i,
  input  wire logic        mem_we_i,
  input  wire logic [1:0]  mem_be_i,
  input  wire logic [12:0] mem_addr_i,
  input  wire logic [15:0] mem_dat_i,
  input  wire logic        acc_we_i,
  input  wire logic        acc_sel_i,
  input  wire logic [39:0] acc_dat_i,
  input  wire logic        sr_we_i,
  input  wire logic [15:0] sr_dat_i,
  input  wire logic [15:0] sr_mask_i
);
  // State preloaded by the bench
  logic [15:0] w [16];
  logic [15:0] mem [8192];
  logic [39:0] acc_a;
  logic [39:0] acc_b;
  logic [15:0] sr;
  // Operand reads, mode 1 is register indirect
  assign base_val_o = w[base_idx_i];
  assign src_val_o  = src_mode_i == 3'h1 ? mem[w[src_idx_i][12:0]] : w[src_idx_i];
  assign file_val_o = mem[file_addr_i];
  assign acc_a_o    = acc_a;
  assign acc_b_o    = acc_b;
  assign sr_o       = sr;
  // Write-back of results with lane enables
  always @(posedge clock_i) begin
    if (rf_we_i[0] && rf_be0_i[0]) w[rf_idx0_i][7:0] <= rf_dat0_i[7:0];
    if (rf_we_i[0] && rf_be0_i[1]) w[rf_idx0_i][15:8] <= rf_dat0_i[15:8];
    if (rf_we_i[1]) w[rf_idx1_i] <= rf_dat1_i;
    if (mem_we_i && mem_be_i[0]) mem[mem_addr_i][7:0] <= mem_dat_i[7:0];
    if (mem_we_i && mem_be_i[1]) mem[mem_addr_i][15:8] <= mem_dat_i[15:8];
    if (acc_we_i && acc_sel_i) acc_b <= acc_dat_i;
    if (acc_we_i && !acc_sel_i) acc_a <= acc_dat_i;
    if (sr_we_i) sr <= (sr & ~sr_mask_i) | (sr_dat_i & sr_mask_i);
  end
endmodule
`default_nettype wire

// file: rtl/mne_exec_unit.sv
`include "mne_params.svh"
`timescale 1ns/1ps
`default_nettype none
module mne_exec_unit (
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             irq_o,
  // Instruction from decoder
  input  wire logic        instr_valid_i,
  input  wire logic [23:0] instr_word_i,
  // Operand fetch requests
  output logic      [3:0]  base_idx_o,
  output logic      [3:0]  src_idx_o,
  output logic      [2:0]  src_mode_o,
  output logic      [2:0]  dst_mode_o,
  output logic      [12:0] file_addr_o,
  output mne_pkg::mne_op_type op_o,
  // Operand values
  input  wire logic [15:0] base_val_i,
  input  wire logic [15:0] src_val_i,
  input  wire logic [15:0] file_val_i,
  input  wire logic [39:0] acc_a_i,
  input  wire logic [39:0] acc_b_i,
  input  wire logic [15:0] sr_i,
  // Register file write ports
  output logic      [1:0]  rf_we_o,
  output logic      [1:0]  rf_be0_o,
  output logic      [3:0]  rf_idx0_o,
  output logic      [15:0] rf_dat0_o,
  output logic      [3:0]  rf_idx1_o,
  output logic      [15:0] rf_dat1_o,
  output logic      [2:0]  rf_mode0_o,
  // Data memory write
  output logic             mem_we_o,
  output logic      [1:0]  mem_be_o,
  output logic      [12:0] mem_addr_o,
  output logic      [15:0] mem_dat_o,
  // Accumulator write
  output logic             acc_we_o,
  output logic             acc_sel_o,
  output logic      [39:0] acc_dat_o,
  // Status register update
  output logic             sr_we_o,
  output logic      [15:0] sr_dat_o,
  output logic      [15:0] sr_mask_o,
  output logic             done_o
);
  import mne_pkg::*;

  // Field split of the instruction word
  wire [7:0]  opc    = instr_word_i[23:16];
  wire        bit15  = instr_word_i[15];
  wire [3:0]  f_w    = instr_word_i[14:11];
  wire [3:0]  f_d    = instr_word_i[10:7];
  wire [2:0]  f_p    = instr_word_i[6:4];
  wire [3:0]  f_s    = instr_word_i[3:0];
  wire [4:0]  f_k    = instr_word_i[4:0];
  wire [2:0]  f_q    = instr_word_i[13:11];
  wire        f_byte = instr_word_i[14];
  wire        f_dbit = instr_word_i[13];
  wire [12:0] f_f    = instr_word_i[12:0];
  wire        is_lit = (instr_word_i[6:5] == `MNE_LIT_TAG);

  // Control registers
  logic [31:0] ctrl_r;
  logic [`MNE_EV_W-1:0] stat_r;
  logic [`MNE_EV_W-1:0] mask_r;
  logic [31:0] count_r;
  logic [31:0] last_r;
  wire run = ctrl_r[`MNE_CTRL_EN];

  // Instruction classification
  wire op_acc_ok = (instr_word_i[14:12] == `MNE_ACC_TAG);
  mne_op_type op;
  assign op = !(instr_valid_i && run) ? MNE_OP_NONE :
              (opc == `MNE_OP_MUL && bit15) ? MNE_OP_MULT_UNSIGNED_BY_SIGNED :
              (opc == `MNE_OP_MUL && is_lit) ? MNE_OP_MUL_LIT :
              (opc == `MNE_OP_MUL) ? MNE_OP_MULT_BOTH_UNSIGNED :
              (opc == `MNE_OP_NEG_F && !bit15) ? MNE_OP_NEG_F :
              (opc == `MNE_OP_NEG_W && !bit15) ? MNE_OP_NEG_W :
              (opc == `MNE_OP_NEG_ACC && op_acc_ok) ? MNE_OP_NEG_ACC :
              MNE_OP_BAD;
  wire is_mul = (op == MNE_OP_MULT_UNSIGNED_BY_SIGNED) || (op == MNE_OP_MULT_BOTH_UNSIGNED) || (op == MNE_OP_MUL_LIT);
  wire is_neg8 = (op == MNE_OP_NEG_F) || (op == MNE_OP_NEG_W);

  // Operand fetch steering
  assign base_idx_o  = f_w;
  assign src_idx_o   = f_s;
  assign src_mode_o  = is_mul ? f_p : (op == MNE_OP_NEG_W) ? f_p : 3'h0;
  assign dst_mode_o  = (op == MNE_OP_NEG_W) ? f_q : 3'h0;
  assign file_addr_o = f_f;
  assign op_o        = op;

  // Odd or W14 destination pair is flagged
  wire bad_dst = is_mul && (f_d[0] || f_d == `MNE_W14);

  // Multiply products
  wire [32:0] prod_us = $signed({1'b0, base_val_i}) * $signed({src_val_i[15], src_val_i});
  wire [31:0] prod_uu = base_val_i * src_val_i;
  wire [31:0] prod_lt = base_val_i * {11'h000, f_k};
  wire [31:0] prod = (op == MNE_OP_MULT_UNSIGNED_BY_SIGNED) ? prod_us[31:0] :
                     (op == MNE_OP_MUL_LIT) ? prod_lt : prod_uu;

  // Negate operand and byte lane
  wire        lane_hi = (op == MNE_OP_NEG_F) && f_f[0];
  wire [15:0] nsrc = (op == MNE_OP_NEG_F) ? file_val_i : src_val_i;
  wire [7:0]  nbyte = lane_hi ? nsrc[15:8] : nsrc[7:0];
  wire [15:0] nop16 = f_byte ? {8'h00, nbyte} : nsrc;
  wire [15:0] nres = ~nop16 + 16'h0001;
  wire [15:0] nres_w = f_byte ? {nres[7:0], nres[7:0]} : nres;

  // Arithmetic flags of negate
  wire fl_c  = f_byte ? (nbyte == 8'h00) : (nsrc == 16'h0000);
  wire fl_z  = f_byte ? (nres[7:0] == 8'h00) : (nres == 16'h0000);
  wire fl_n  = f_byte ? nres[7] : nres[15];
  wire fl_ov = f_byte ? (nbyte == 8'h80) : (nsrc == 16'h8000);
  wire fl_dc = f_byte ? (nbyte[3:0] == 4'h0) : (nsrc[7:0] == 8'h00);
  wire [15:0] ar_mask = (16'h0001 << `MNE_SR_C) | (16'h0001 << `MNE_SR_Z) |
                        (16'h0001 << `MNE_SR_OV) | (16'h0001 << `MNE_SR_N) |
                        (16'h0001 << `MNE_SR_DC);
  wire [15:0] ar_flags;
  assign ar_flags = ({15'h0000, fl_c} << `MNE_SR_C) | ({15'h0000, fl_z} << `MNE_SR_Z) |
                    ({15'h0000, fl_ov} << `MNE_SR_OV) | ({15'h0000, fl_n} << `MNE_SR_N) |
                    ({15'h0000, fl_dc} << `MNE_SR_DC);

  // Accumulator negate over 40 bits
  wire        asel = bit15;
  wire [39:0] aop = asel ? acc_b_i : acc_a_i;
  wire [39:0] ares = ~aop + 40'h00_0000_0001;
  wire        a_ov = !((&ares[39:31]) || !(|ares[39:31]));
  wire        a_sat = (aop == 40'h80_0000_0000);
  wire oa = asel ? sr_i[`MNE_SR_OA] : a_ov;
  wire ob = asel ? a_ov : sr_i[`MNE_SR_OB];
  wire sa = asel ? sr_i[`MNE_SR_SA] : (sr_i[`MNE_SR_SA] | a_sat);
  wire sb = asel ? (sr_i[`MNE_SR_SB] | a_sat) : sr_i[`MNE_SR_SB];
  wire [15:0] acc_flags;
  assign acc_flags = ({15'h0000, oa} << `MNE_SR_OA) | ({15'h0000, ob} << `MNE_SR_OB) |
                     ({15'h0000, oa | ob} << `MNE_SR_OAB) | ({15'h0000, sa} << `MNE_SR_SA) |
                     ({15'h0000, sb} << `MNE_SR_SB) | ({15'h0000, sa | sb} << `MNE_SR_SAB);
  wire [15:0] acc_mask = (16'h0001 << `MNE_SR_OA) | (16'h0001 << `MNE_SR_OB) |
                         (16'h0001 << `MNE_SR_OAB) | (16'h0001 << `MNE_SR_SA) |
                         (16'h0001 << `MNE_SR_SB) | (16'h0001 << `MNE_SR_SAB);

  // Next values of the write ports
  wire        neg_to_w  = (op == MNE_OP_NEG_W) || (op == MNE_OP_NEG_F && !f_dbit);
  wire [1:0]  be_nxt = !f_byte ? 2'h3 : (lane_hi && !neg_to_w) ? 2'h2 : 2'h1;
  wire [1:0]  rf_we_nxt = is_mul ? 2'h3 : neg_to_w ? 2'h1 : 2'h0;
  wire [3:0]  rf_idx0_nxt = is_mul ? f_d : (op == MNE_OP_NEG_W) ? f_d : `MNE_W0;
  wire [15:0] rf_dat0_nxt = is_mul ? prod[15:0] : nres_w;
  wire [3:0]  rf_idx1_nxt = f_d | 4'h1;
  wire        mem_we_nxt = (op == MNE_OP_NEG_F) && f_dbit;
  wire        sr_we_nxt = is_neg8 || (op == MNE_OP_NEG_ACC);
  wire [15:0] sr_mask_nxt = (op == MNE_OP_NEG_ACC) ? acc_mask : is_neg8 ? ar_mask : 16'h0000;
  wire [15:0] sr_dat_nxt = (op == MNE_OP_NEG_ACC) ? acc_flags : ar_flags;
  wire        exec = (op != MNE_OP_NONE) && (op != MNE_OP_BAD);

  // Result stage, one cycle per instruction
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rf_we_o    <= 2'h0;
      rf_be0_o   <= 2'h0;
      rf_idx0_o  <= 4'h0;
      rf_dat0_o  <= 16'h0000;
      rf_idx1_o  <= 4'h0;
      rf_dat1_o  <= 16'h0000;
      rf_mode0_o <= 3'h0;
      mem_we_o   <= 1'b0;
      mem_be_o   <= 2'h0;
      mem_addr_o <= 13'h0000;
      mem_dat_o  <= 16'h0000;
      acc_we_o   <= 1'b0;
      acc_sel_o  <= 1'b0;
      acc_dat_o  <= 40'h00_0000_0000;
      sr_we_o    <= 1'b0;
      sr_dat_o   <= 16'h0000;
      sr_mask_o  <= 16'h0000;
      done_o     <= 1'b0;
    end else if (clk_en_i) begin
      rf_we_o    <= rf_we_nxt;
      rf_be0_o   <= is_mul ? 2'h3 : be_nxt;
      rf_idx0_o  <= rf_idx0_nxt;
      rf_dat0_o  <= rf_dat0_nxt;
      rf_idx1_o  <= rf_idx1_nxt;
      rf_dat1_o  <= prod[31:16];
      rf_mode0_o <= dst_mode_o;
      mem_we_o   <= mem_we_nxt;
      mem_be_o   <= be_nxt;
      mem_addr_o <= f_f;
      mem_dat_o  <= nres_w;
      acc_we_o   <= (op == MNE_OP_NEG_ACC);
      acc_sel_o  <= asel;
      acc_dat_o  <= ares;
      sr_we_o    <= sr_we_nxt;
      sr_dat_o   <= sr_dat_nxt;
      sr_mask_o  <= sr_mask_nxt;
      done_o     <= exec;
    end
  end

  // Events for the sticky status register
  wire [`MNE_EV_W-1:0] ev;
  assign ev = {(op == MNE_OP_BAD), bad_dst, (is_neg8 || op == MNE_OP_NEG_ACC), is_mul};

  // Bus decode
  wire req  = avs_read_i || avs_write_i;
  logic ack_r;
  wire ack_nxt = req && !ack_r;
  wire wr_go = avs_write_i && ack_r;
  wire sel_ctrl  = (avs_address_i == `MNE_REG_CTRL);
  wire sel_stat  = (avs_address_i == `MNE_REG_STAT);
  wire sel_mask  = (avs_address_i == `MNE_REG_MASK);
  wire sel_count = (avs_address_i == `MNE_REG_COUNT);
  wire sel_last  = (avs_address_i == `MNE_REG_LAST);
  wire [31:0] be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wmask = avs_writedata_i & be_mask;
  wire [31:0] ctrl_nxt = (ctrl_r & ~be_mask) | wmask;
  wire [`MNE_EV_W-1:0] w1c = (wr_go && sel_stat) ? wmask[`MNE_EV_W-1:0] : {`MNE_EV_W{1'b0}};
  wire [`MNE_EV_W-1:0] stat_nxt = (stat_r & ~w1c) | ev;
  wire [31:0] rd_mux = sel_ctrl  ? ctrl_r :
                       sel_stat  ? {{(32-`MNE_EV_W){1'b0}}, stat_r} :
                       sel_mask  ? {{(32-`MNE_EV_W){1'b0}}, mask_r} :
                       sel_count ? count_r :
                       sel_last  ? last_r : 32'h0000_0000;

  assign avs_waitrequest_o = req && !ack_r;
  assign irq_o = |(stat_r & mask_r);

  // Bus handshake and read data
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_r          <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else if (clk_en_i) begin
      ack_r <= ack_nxt;
      if (ack_nxt) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // Software registers, status set wins over clear, count clear wins over increment
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r  <= `MNE_CTRL_RST;
      stat_r  <= {`MNE_EV_W{1'b0}};
      mask_r  <= {`MNE_EV_W{1'b0}};
      count_r <= 32'h0000_0000;
      last_r  <= 32'h0000_0000;
    end else if (clk_en_i) begin
      stat_r <= stat_nxt;
      if (wr_go && sel_ctrl) begin
        ctrl_r <= ctrl_nxt;
      end
      if (wr_go && sel_mask) begin
        mask_r <= wmask[`MNE_EV_W-1:0];
      end
      if (wr_go && sel_count) begin
        count_r <= 32'h0000_0000;
      end else if (exec) begin
        count_r <= count_r + 32'h0000_0001;
      end
      if (is_mul) begin
        last_r <= prod;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/mne_params.svh
`ifndef MNE_PARAMS_SVH
`define MNE_PARAMS_SVH
// Opcode high bytes, field tags and register numbers
`define MNE_OP_MUL     8'hb8
`define MNE_OP_NEG_F   8'hee
`define MNE_OP_NEG_W   8'hea
`define MNE_OP_NEG_ACC 8'hcb
`define MNE_ACC_TAG    3'h1
`define MNE_LIT_TAG    2'h3
`define MNE_W0         4'h0
`define MNE_W14        4'he
// Register byte offsets
`define MNE_REG_CTRL   5'h00
`define MNE_REG_STAT   5'h04
`define MNE_REG_MASK   5'h08
`define MNE_REG_COUNT  5'h0c
`define MNE_REG_LAST   5'h10
// Control bits
`define MNE_CTRL_EN    0
`define MNE_CTRL_IF    1
`define MNE_CTRL_RST   32'h0000_0001
// Event bits
`define MNE_EV_MUL     0
`define MNE_EV_NEG     1
`define MNE_EV_BADDST  2
`define MNE_EV_BADOP   3
`define MNE_EV_W       4
// Status register flag positions
`define MNE_SR_C       0
`define MNE_SR_Z       1
`define MNE_SR_OV      2
`define MNE_SR_N       3
`define MNE_SR_DC      8
`define MNE_SR_SAB     10
`define MNE_SR_OAB     11
`define MNE_SR_SB      12
`define MNE_SR_SA      13
`define MNE_SR_OB      14
`define MNE_SR_OA      15
`endif

// file: rtl/mne_pkg.sv
package mne_pkg;
  // Instruction classes seen by the unit
  typedef enum logic [2:0] {
    MNE_OP_NONE,
    MNE_OP_MULT_UNSIGNED_BY_SIGNED,
    MNE_OP_MULT_BOTH_UNSIGNED,
    MNE_OP_MUL_LIT,
    MNE_OP_NEG_F,
    MNE_OP_NEG_W,
    MNE_OP_NEG_ACC,
    MNE_OP_BAD
  } mne_op_type;
endpackage
